// [src/ttr_pkg.sv]
// Package: register map, field layout and reset values of the trim/option/ident bank
package ttr_pkg;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] VENDOR_CMD_EE = 8'hEE;
  localparam logic [7:0] VENDOR_CMD_F0 = 8'hF0;
  localparam logic [7:0] VENDOR_CMD_FC = 8'hFC;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam logic [4:0]  TRIM_EXPONENT     = 5'h1F;
  localparam int          TRIM_EXP_LSB      = 11;
  localparam logic [10:0] TRIM_MANT_RESET   = 11'h000;
  localparam logic [10:0] TRIM_MANT_MIN     = 11'h7F8;
  localparam logic [10:0] TRIM_MANT_MAX     = 11'h006;
  localparam logic [15:0] TRIM_RESET        = 16'hF800;
  localparam logic [15:0] OPTIONS_RESET     = 16'h0000;
  localparam int          OPT_WR_BITS       = 6;
  localparam int          OPT_VAL_HIGH_BIT  = 5;
  localparam int          OPT_VAL_EN_BIT    = 4;
  localparam int          OPT_AVG_BIT       = 3;
  localparam int          OPT_INJ_EN_BIT    = 2;
  localparam int          REV_WIDTH         = 4;

  // ----------------------------------------
  // Thresholds in mV
  // ----------------------------------------
  localparam logic [7:0] VALLEY_MV_LOW  = 8'h32;
  localparam logic [7:0] VALLEY_MV_HIGH = 8'h64;
  localparam logic [7:0] INJ_MV_00      = 8'h23;
  localparam logic [7:0] INJ_MV_01      = 8'h3C;
  localparam logic [7:0] INJ_MV_10      = 8'h55;
  localparam logic [7:0] INJ_MV_11      = 8'h6E;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic       valley_threshold_high;
    logic       valley_blank_enable;
    logic       injection_average_mode;
    logic       pulse_injection_enable;
    logic [1:0] injection_threshold_select;
  } ttr_opts_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] cmd;
    logic       page;
    logic [15:0] wdata;
  } ttr_req_t;

  typedef enum logic [2:0] {
    TTR_IDLE = 3'b001,
    TTR_LOAD = 3'b010,
    TTR_RUN  = 3'b100
  } ttr_state_t;

endpackage

// [src/ttr_chan_proc.sv]
// One channel: offset applied to averaged temperature, option gating of transient responses
`timescale 1ns/1ps
module ttr_chan_proc (
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RESET_N_I,
  // Settings
  input  wire logic [10:0]         TRIM_MANT_I,
  input  wire ttr_pkg::ttr_opts_t  OPTS_I,
  // Temperature path, half-degree units, two's complement
  input  wire logic signed [15:0]  TEMP_AVG_I,
  output logic signed [15:0]       TEMP_OUT_O,
  // Comparator inputs
  input  wire logic                RISE_PEAK_I,
  input  wire logic                RISE_AVG_I,
  input  wire logic                FALL_PEAK_I,
  input  wire logic                FALL_AVG_I,
  // Controls to analog and power stage
  output logic [7:0]               INJ_THRESH_MV_O,
  output logic [7:0]               VALLEY_THRESH_MV_O,
  output logic                     INJECT_PULSE_O,
  output logic                     DRIVE_OFF_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] inj_mv(input logic [1:0] sel);
    unique case (sel)
      2'b00: inj_mv = ttr_pkg::INJ_MV_00;
      2'b01: inj_mv = ttr_pkg::INJ_MV_01;
      2'b10: inj_mv = ttr_pkg::INJ_MV_10;
      2'b11: inj_mv = ttr_pkg::INJ_MV_11;
    endcase
  endfunction

  logic rise_det;
  logic fall_det;

  assign rise_det = OPTS_I.injection_average_mode ? RISE_AVG_I : RISE_PEAK_I;
  assign fall_det = OPTS_I.injection_average_mode ? FALL_AVG_I : FALL_PEAK_I;

  // ----------------------------------------
  // Temperature
  // ----------------------------------------
  // offset after math
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TEMP_OUT_O <= 16'sh0000;
    end else begin
      TEMP_OUT_O <= TEMP_AVG_I + 16'(signed'(TRIM_MANT_I));
    end
  end

  // ----------------------------------------
  // Transient responses
  // ----------------------------------------
  // threshold select
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      INJ_THRESH_MV_O    <= ttr_pkg::INJ_MV_00;
      VALLEY_THRESH_MV_O <= ttr_pkg::VALLEY_MV_LOW;
    end else begin
      INJ_THRESH_MV_O    <= inj_mv(OPTS_I.injection_threshold_select);
      VALLEY_THRESH_MV_O <= OPTS_I.valley_threshold_high ? ttr_pkg::VALLEY_MV_HIGH
                                                         : ttr_pkg::VALLEY_MV_LOW;
    end
  end

  // Response gated so a disabled option never touches the switches
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      INJECT_PULSE_O <= 1'b0;
      DRIVE_OFF_O    <= 1'b0;
    end else begin
      INJECT_PULSE_O <= OPTS_I.pulse_injection_enable & rise_det;
      DRIVE_OFF_O    <= OPTS_I.valley_blank_enable & fall_det;
    end
  end

endmodule

// [src/ttr_regs.sv]
// Top: paged temperature trim, pulse-injection options and part identifier registers
`timescale 1ns/1ps

// Behaviour
// - Offset trim is added to processed temperature after conversion arithmetic.
// - Offset temperature feeds readback and current-sense gain compensation.
// - Trim exponent bits 7:3 of high byte fixed at minus one.
// - Mantissa eleven-bit two's complement, zero default, valid 7F8 to 006.
// - Trim resets to F800, options to 0000; nonvolatile values may replace them.
// - Trim and options are held per channel, chosen by page.
// - Options bits 15 to 6 read-only; writes ignored.
// - Valley-high bit raises valley threshold from 50 to 100 mV.
// - Valley enable plus large fall turns off both switches.
// - Average-mode bit selects averaged error output for detection.
// - Injection enable plus large rise inserts extra pulses.
// - Identifier read-only, 16 bits: 12-bit part code, 4-bit revision.
module ttr_regs #(
  parameter int          NUM_CH   = 2,
  parameter logic [11:0] PART_ID  = 12'hA5C,  // Arbitrary value
  parameter logic [3:0]  REVISION = 4'h0
) (
  // Clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RESET_N_I,
  // Command port from protocol engine
  input  wire ttr_pkg::ttr_req_t          REQ_I,
  output logic [15:0]                     RDATA_O,
  output logic                            RVALID_O,
  output logic                            HIT_O,
  // Nonvolatile restore
  input  wire logic                       NVM_LOAD_I,
  input  wire logic [NUM_CH-1:0][15:0]    NVM_TRIM_I,
  input  wire logic [NUM_CH-1:0][15:0]    NVM_OPTS_I,
  // Temperature path
  input  wire logic [NUM_CH-1:0][15:0]    TEMP_AVG_I,
  output logic [NUM_CH-1:0][15:0]         TEMP_READ_O,
  output logic [NUM_CH-1:0][15:0]         GAIN_COMP_TEMP_O,
  // Comparators
  input  wire logic [NUM_CH-1:0]          RISE_PEAK_I,
  input  wire logic [NUM_CH-1:0]          RISE_AVG_I,
  input  wire logic [NUM_CH-1:0]          FALL_PEAK_I,
  input  wire logic [NUM_CH-1:0]          FALL_AVG_I,
  // Controls
  output logic [NUM_CH-1:0][7:0]          INJ_THRESH_MV_O,
  output logic [NUM_CH-1:0][7:0]          VALLEY_THRESH_MV_O,
  output logic [NUM_CH-1:0]               INJECT_PULSE_O,
  output logic [NUM_CH-1:0]               DRIVE_OFF_O,
  output logic                            TRIM_RANGE_ERR_O
);

  // Page select is one bit, so no other channel count can be reached
  if (NUM_CH != 2) begin : g_bad_num_ch
    $error("ttr_regs serves exactly two channels");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic trim_valid(input logic [10:0] m);
    trim_valid = ($signed(m) >= $signed(ttr_pkg::TRIM_MANT_MIN)) &&
                 ($signed(m) <= $signed(ttr_pkg::TRIM_MANT_MAX));
  endfunction

  logic [10:0]          trim_q [NUM_CH];
  ttr_pkg::ttr_opts_t   opts_q [NUM_CH];
  logic                 wr_trim;
  logic                 wr_opts;
  logic                 pg;
  logic [10:0]          wmant;

  assign pg      = REQ_I.page;
  assign wmant   = REQ_I.wdata[10:0];
  assign wr_trim = REQ_I.wr_en && (REQ_I.cmd == ttr_pkg::VENDOR_CMD_EE);
  assign wr_opts = REQ_I.wr_en && (REQ_I.cmd == ttr_pkg::VENDOR_CMD_F0);

  // ----------------------------------------
  // Storage per channel
  // ----------------------------------------
  // per-page storage
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          trim_q[c] <= ttr_pkg::TRIM_RESET[10:0];
          opts_q[c] <= ttr_pkg::OPTIONS_RESET[ttr_pkg::OPT_WR_BITS-1:0];
        end else if (NVM_LOAD_I) begin
          trim_q[c] <= NVM_TRIM_I[c][10:0];
          opts_q[c] <= NVM_OPTS_I[c][ttr_pkg::OPT_WR_BITS-1:0];
        end else begin
          if (wr_trim && (pg == 1'(c)) && trim_valid(wmant)) begin
            trim_q[c] <= wmant;
          end
          if (wr_opts && (pg == 1'(c))) begin
            opts_q[c] <= REQ_I.wdata[ttr_pkg::OPT_WR_BITS-1:0];
          end
        end
      end

      ttr_chan_proc u_chan (
        .CLK_I              (CLK_I),
        .RESET_N_I          (RESET_N_I),
        .TRIM_MANT_I        (trim_q[c]),
        .OPTS_I             (opts_q[c]),
        .TEMP_AVG_I         (TEMP_AVG_I[c]),
        .TEMP_OUT_O         (TEMP_READ_O[c]),
        .RISE_PEAK_I        (RISE_PEAK_I[c]),
        .RISE_AVG_I         (RISE_AVG_I[c]),
        .FALL_PEAK_I        (FALL_PEAK_I[c]),
        .FALL_AVG_I         (FALL_AVG_I[c]),
        .INJ_THRESH_MV_O    (INJ_THRESH_MV_O[c]),
        .VALLEY_THRESH_MV_O (VALLEY_THRESH_MV_O[c]),
        .INJECT_PULSE_O     (INJECT_PULSE_O[c]),
        .DRIVE_OFF_O        (DRIVE_OFF_O[c])
      );

      assign GAIN_COMP_TEMP_O[c] = TEMP_READ_O[c];
    end
  endgenerate

  // ----------------------------------------
  // Range flag
  // ----------------------------------------
  // Out-of-range trim write is dropped; flag lets protocol engine raise its fault
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TRIM_RANGE_ERR_O <= 1'b0;
    end else begin
      TRIM_RANGE_ERR_O <= wr_trim && !NVM_LOAD_I && !trim_valid(wmant);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      RDATA_O  <= 16'h0000;
      RVALID_O <= 1'b0;
      HIT_O    <= 1'b0;
    end else begin
      RVALID_O <= REQ_I.rd_en;
      HIT_O    <= 1'b0;
      RDATA_O  <= 16'h0000;
      if (REQ_I.rd_en) begin
        unique case (REQ_I.cmd)
          ttr_pkg::VENDOR_CMD_EE: begin
            RDATA_O <= {ttr_pkg::TRIM_EXPONENT, trim_q[pg]};
            HIT_O   <= 1'b1;
          end
          ttr_pkg::VENDOR_CMD_F0: begin
            RDATA_O <= {10'h000, opts_q[pg]};
            HIT_O   <= 1'b1;
          end
          ttr_pkg::VENDOR_CMD_FC: begin
            RDATA_O <= {PART_ID, REVISION};
            HIT_O   <= 1'b1;
          end
          default: begin
            RDATA_O <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule

// [tb/ttr_host.sv]
// Host-side model issuing one-cycle register requests
`timescale 1ns/1ps
module ttr_host (
  // Clock
  input  wire logic         CLK_I,
  // Request and answer
  output ttr_pkg::ttr_req_t REQ_O,
  input  wire logic [15:0]  RDATA_I,
  input  wire logic         RVALID_I,
  input  wire logic         HIT_I
);
  initial REQ_O = '0;
  task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] v);
    @(posedge CLK_I);
    REQ_O <= {1'b1, 1'b0, c, p, v};
    @(posedge CLK_I);
    REQ_O <= '0;
  endtask
  // Answer lands on the taking edge and is sampled 1 ns after it
  task automatic rd(input logic [7:0] c, input logic p, output logic [15:0] v,
                    output logic [1:0] f);
    @(posedge CLK_I);
    REQ_O <= {1'b0, 1'b1, c, p, 16'h0000};
    @(posedge CLK_I);
    REQ_O <= '0;
    #1;
    v = RDATA_I;
    f = {RVALID_I, HIT_I};
  endtask
endmodule

// [tb/ttr_regs_monitor.sv]
// Checker of the trim/option/ident bank ports
`timescale 1ns/1ps
module ttr_regs_monitor #(
  parameter int          NUM_CH   = 2,
  parameter logic [11:0] PART_ID  = 12'hA5C,
  parameter logic [3:0]  REVISION = 4'h0
) (
  // Watched ports
  input wire logic                    CLK_I,
  input wire logic                    RESET_N_I,
  input wire ttr_pkg::ttr_req_t       REQ_I,
  input wire logic [15:0]             RDATA_O,
  input wire logic                    RVALID_O,
  input wire logic                    HIT_O,
  input wire logic [NUM_CH-1:0][15:0] TEMP_READ_O,
  input wire logic [NUM_CH-1:0][15:0] GAIN_COMP_TEMP_O,
  input wire logic [NUM_CH-1:0]       RISE_PEAK_I,
  input wire logic [NUM_CH-1:0]       RISE_AVG_I,
  input wire logic [NUM_CH-1:0]       FALL_PEAK_I,
  input wire logic [NUM_CH-1:0]       FALL_AVG_I,
  input wire logic [NUM_CH-1:0][7:0]  INJ_THRESH_MV_O,
  input wire logic [NUM_CH-1:0][7:0]  VALLEY_THRESH_MV_O,
  input wire logic [NUM_CH-1:0]       INJECT_PULSE_O,
  input wire logic [NUM_CH-1:0]       DRIVE_OFF_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_id;
    REQ_I.rd_en && REQ_I.cmd == 8'hFC |=> HIT_O && RDATA_O == {PART_ID, REVISION};
  endproperty
  a_id: assert property (p_id) else $error("ident read wrong");
  property p_exp;
    REQ_I.rd_en && REQ_I.cmd == 8'hEE |=> RVALID_O && RDATA_O[15:11] == 5'h1F;
  endproperty
  a_exp: assert property (p_exp) else $error("trim exponent wrong");
  property p_ro;
    REQ_I.rd_en && REQ_I.cmd == 8'hF0 |=> HIT_O && RDATA_O[15:6] == 10'h000;
  endproperty
  a_ro: assert property (p_ro) else $error("option upper bits set");
  property p_idle;
    !RVALID_O |-> RDATA_O == 16'h0000 && !HIT_O;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without valid");
  property p_gain;
    TEMP_READ_O == GAIN_COMP_TEMP_O;
  endproperty
  a_gain: assert property (p_gain) else $error("gain temperature differs");
  property p_inj;
    (INJECT_PULSE_O & ~$past(RISE_PEAK_I | RISE_AVG_I)) == '0;
  endproperty
  a_inj: assert property (p_inj) else $error("injection without rise");
  property p_off;
    (DRIVE_OFF_O & ~$past(FALL_PEAK_I | FALL_AVG_I)) == '0;
  endproperty
  a_off: assert property (p_off) else $error("drive off without fall");
  property p_valley;
    VALLEY_THRESH_MV_O[0] inside {8'h32, 8'h64} && VALLEY_THRESH_MV_O[1] inside {8'h32, 8'h64};
  endproperty
  a_valley: assert property (p_valley) else $error("valley threshold wrong");
  property p_thr;
    INJ_THRESH_MV_O[0] inside {8'h23, 8'h3C, 8'h55, 8'h6E} &&
    INJ_THRESH_MV_O[1] inside {8'h23, 8'h3C, 8'h55, 8'h6E};
  endproperty
  a_thr: assert property (p_thr) else $error("injection threshold wrong");
endmodule
bind ttr_regs ttr_regs_monitor #(.NUM_CH(NUM_CH), .PART_ID(PART_ID), .REVISION(REVISION))
  u_mon (.CLK_I, .RESET_N_I, .REQ_I, .RDATA_O, .RVALID_O, .HIT_O, .TEMP_READ_O,
  .GAIN_COMP_TEMP_O, .RISE_PEAK_I, .RISE_AVG_I, .FALL_PEAK_I, .FALL_AVG_I,
  .INJ_THRESH_MV_O, .VALLEY_THRESH_MV_O, .INJECT_PULSE_O, .DRIVE_OFF_O);

// [tb/tb.sv]
// Self-checking bench of the trim/option/ident bank
`timescale 1ns/1ps
module tb;
  logic              clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  ttr_pkg::ttr_req_t req;
  logic [15:0]       rdata, d;
  logic              rvalid, hit, rng_err;
  logic              nvm_load = 1'b0;
  logic [1:0][15:0]  nvm_trim = '0, nvm_opts = '0, temp_avg = '0, temp_rd, gain_t;
  logic [1:0]        rpk = '0, ravg = '0, fpk = '0, favg = '0, inj, drv, f;
  logic [1:0][7:0]   inj_mv, val_mv;
  logic [7:0]        mv [4] = '{8'h23, 8'h3C, 8'h55, 8'h6E};
  int                bad_count = 0;
  int                samples_checked = 0;
  always #5 clk_i = ~clk_i;
  // Arbitrary part code
  ttr_regs #(.PART_ID(12'h3B7)) dut (.CLK_I(clk_i), .RESET_N_I(reset_n_i), .REQ_I(req),
    .RDATA_O(rdata), .RVALID_O(rvalid), .HIT_O(hit), .NVM_LOAD_I(nvm_load),
    .NVM_TRIM_I(nvm_trim), .NVM_OPTS_I(nvm_opts), .TEMP_AVG_I(temp_avg),
    .TEMP_READ_O(temp_rd), .GAIN_COMP_TEMP_O(gain_t), .RISE_PEAK_I(rpk), .RISE_AVG_I(ravg),
    .FALL_PEAK_I(fpk), .FALL_AVG_I(favg), .INJ_THRESH_MV_O(inj_mv),
    .VALLEY_THRESH_MV_O(val_mv), .INJECT_PULSE_O(inj), .DRIVE_OFF_O(drv),
    .TRIM_RANGE_ERR_O(rng_err));
  ttr_host host (.CLK_I(clk_i), .REQ_O(req), .RDATA_I(rdata), .RVALID_I(rvalid), .HIT_I(hit));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] c, input logic p, input logic [15:0] exp);
    host.rd(c, p, d, f);
    chk("read flags", 16'h0003, {14'h0, f});
    chk("read data", exp, d);
  endtask
  // Registered outputs need one edge after a setting lands; settle waits two
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc(8'hEE, 1'b0, 16'hF800);
    rdc(8'hEE, 1'b1, 16'hF800);
    rdc(8'hF0, 1'b1, 16'h0000);
    rdc(8'hFC, 1'b0, 16'h3B70);
    chk("inj mv", 16'h2323, inj_mv);
    chk("valley mv", 16'h3232, val_mv);
    $display("test reset done");
    host.wr(8'hEE, 1'b1, 16'h0006);
    host.wr(8'hEE, 1'b0, 16'h07F8);
    rdc(8'hEE, 1'b1, 16'hF806);
    rdc(8'hEE, 1'b0, 16'hFFF8);
    host.wr(8'hEE, 1'b1, 16'h0007);
    #1;
    chk("range err", 16'h0001, {15'h0, rng_err});
    rdc(8'hEE, 1'b1, 16'hF806);
    host.wr(8'hEE, 1'b1, 16'h0003);
    rdc(8'hEE, 1'b1, 16'hF803);
    host.wr(8'hFC, 1'b0, 16'hFFFF);
    rdc(8'hFC, 1'b0, 16'h3B70);
    @(posedge clk_i) temp_avg <= {16'h0014, 16'h0014};
    settle();
    chk("temp ch1", 16'h0017, temp_rd[1]);
    chk("temp ch0", 16'h000C, temp_rd[0]);
    chk("gain temp", 16'h0017, gain_t[1]);
    chk("gain temp ch0", 16'h000C, gain_t[0]);
    $display("test trim done");
    host.wr(8'hF0, 1'b0, 16'hFFFF);
    rdc(8'hF0, 1'b0, 16'h003F);
    rdc(8'hF0, 1'b1, 16'h0000);
    settle();
    chk("valley mv", 16'h0064, {8'h00, val_mv[0]});
    for (int i = 0; i < 4; i++) begin
      host.wr(8'hF0, 1'b0, 16'(i));
      settle();
      chk("inj mv", {8'h00, mv[i]}, {8'h00, inj_mv[0]});
    end
    chk("valley mv", 16'h0032, {8'h00, val_mv[0]});
    host.wr(8'hF0, 1'b0, 16'h0014);
    @(posedge clk_i) {rpk, fpk} <= 4'h5;
    settle();
    chk("inject", 16'h0001, {14'h0, inj});
    chk("drive off", 16'h0001, {14'h0, drv});
    host.wr(8'hF0, 1'b0, 16'h001C);
    settle();
    chk("inject avg", 16'h0000, {12'h0, inj, drv});
    @(posedge clk_i) {ravg, favg} <= 4'h5;
    settle();
    chk("inject avg", 16'h0005, {12'h0, inj, drv});
    host.wr(8'hF0, 1'b0, 16'h0000);
    settle();
    chk("disabled", 16'h0000, {12'h0, inj, drv});
    $display("test options done");
    @(posedge clk_i) {nvm_trim, nvm_opts, nvm_load} <= {32'h2, 32'h21, 1'b1};
    @(posedge clk_i) nvm_load <= 1'b0;
    rdc(8'hEE, 1'b0, 16'hF802);
    rdc(8'hF0, 1'b0, 16'h0021);
    rdc(8'hEE, 1'b1, 16'hF800);
    $display("test restore done");
    final_report();
  end
endmodule
